// ---- verilog/xbpi_top.sv ----
// Expansion bus pin interface: chip-select cycles, strobes, wait and ready handling, reset strap capture.
// Overview of operation
// R1: Every expansion pin is sampled and launched on the expansion bus clock.
// R2: Multiplexed styles drive an address-latch enable so the address can be latched.
// R3: A 24-bit address is driven out during data accesses.
// R4: During reset the address pins are inputs; the board straps configuration by pull-downs.
// R5: One strobe pin is write strobe in separate style, data strobe otherwise.
// R6: Second strobe pin is read strobe in separate style, read-not-write otherwise.
// R7: Eight active-low chip selects, each separate-strobe or data-strobe style.
// R8: Only chip selects four to seven may use the host-port style.
// R9: A 16-bit bidirectional data bus, driven on writes, received on reads.
// R10: A low wait input freezes the access; it continues when wait returns high.
// R11: Wait is honoured for non-host-port styles only, ignored for host-port.
// R12: Four host-port ready inputs, each with configurable active polarity.
// R13: Each ready belongs to one of chip selects four to seven and stalls only it.
// R14: After reset selects and strobes idle high and address-latch enable low.
// R15: At most one chip select is active, decoded from the access address.
`timescale 1ns/1ps
module xbpi_top
  import xbpi_pkg::*;
(
  // Expansion bus clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Access request from the core side
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic      [15:0] rsp_rdata,
  // Configuration
  input  wire logic [7:0]  cfg_ds_style,
  input  wire logic [3:0]  cfg_hp_style,
  input  wire logic        cfg_mux_mode,
  input  wire logic [3:0]  cfg_rdy_pol,
  output logic      [23:0] strap_cfg,
  // Expansion bus pins
  output logic             xbus_addr_latch_en,
  input  wire logic [23:0] xbus_addr_in,
  output logic      [23:0] xbus_addr_out,
  output logic             xbus_addr_oe,
  output logic             xbus_write_strobe_n,
  output logic             xbus_read_strobe_n,
  output logic      [7:0]  xbus_select_n,
  input  wire logic [15:0] xbus_data_in,
  output logic      [15:0] xbus_data_out,
  output logic             xbus_data_oe,
  input  wire logic        xbus_wait_n,
  input  wire logic [3:0]  hostport_ready
);
  // Pin inputs are synchronised first; the whole block runs on the bus clock. R1
  logic        wait_n_s;
  logic [3:0]  rdy_s;
  logic [15:0] data_s;
  logic [23:0] addr_s;

  xbpi_sync #(.WIDTH(1)) u_sync_wait (
    .clk(clk), .srst(srst), .async_in(xbus_wait_n), .rst_val(1'h1), .sync_out(wait_n_s));
  xbpi_sync #(.WIDTH(4)) u_sync_rdy (
    .clk(clk), .srst(srst), .async_in(hostport_ready), .rst_val(4'hF), .sync_out(rdy_s));
  xbpi_sync #(.WIDTH(16)) u_sync_data (
    .clk(clk), .srst(srst), .async_in(xbus_data_in), .rst_val(XBPI_DATA_RST), .sync_out(data_s));
  xbpi_sync #(.WIDTH(24)) u_sync_addr (
    .clk(clk), .srst(srst), .async_in(xbus_addr_in), .rst_val(24'hFFFFFF), .sync_out(addr_s));

  function automatic logic [2:0] cs_index(input logic [23:0] a);
    cs_index = a[23:XBPI_CS_POS];
  endfunction

  function automatic logic [1:0] cs_style(input logic [2:0] idx, input logic [7:0] ds, input logic [3:0] hp);
    // Host-port style exists only on the upper four selects. R8
    if (idx[2] && hp[idx[1:0]]) begin
      cs_style = XBPI_STY_HP;
    end else if (ds[idx]) begin
      cs_style = XBPI_STY_DS;
    end else begin
      cs_style = XBPI_STY_SEP;
    end
  endfunction

  xbpi_state_t state_ff, nxt_state;
  logic [1:0]  strap_arm_ff, nxt_strap_arm;
  logic [1:0]  hold_cnt_ff, nxt_hold_cnt;
  logic [15:0] dout_ff, nxt_dout;
  logic [23:0] strap_ff, nxt_strap;
  logic [23:0] addr_ff, nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        write_ff, nxt_write;
  logic [2:0]  idx_ff, nxt_idx;
  logic [1:0]  sty_ff, nxt_sty;
  logic        ale_ff, nxt_ale;
  logic        aoe_ff, nxt_aoe;
  logic        doe_ff, nxt_doe;
  logic        wr_n_ff, nxt_wr_n;
  logic        rd_n_ff, nxt_rd_n;
  logic [7:0]  cs_n_ff, nxt_cs_n;
  logic        rdy_ff, nxt_rdy;
  logic        rsp_ff, nxt_rsp;
  logic        stall;
  logic        rdy_act;

  // Ready polarity is per input, and each input pairs with one upper chip select. R12 R13
  assign rdy_act = ~(rdy_s[idx_ff[1:0]] ^ cfg_rdy_pol[idx_ff[1:0]]);

  always_comb begin
    if (sty_ff == XBPI_STY_HP) begin
      stall = ~rdy_act; // R13
    end else begin
      stall = ~wait_n_s; // R10 R11
    end
  end

  always_comb begin
    nxt_state     = state_ff;
    nxt_strap_arm = {1'h0, strap_arm_ff[1]};
    nxt_hold_cnt  = hold_cnt_ff;
    nxt_dout      = dout_ff;
    nxt_strap     = strap_ff;
    nxt_addr      = addr_ff;
    nxt_wdata     = wdata_ff;
    nxt_rdata     = rdata_ff;
    nxt_write     = write_ff;
    nxt_idx       = idx_ff;
    nxt_sty       = sty_ff;
    nxt_ale       = 1'h0;
    nxt_aoe       = aoe_ff;
    nxt_doe       = doe_ff;
    nxt_wr_n      = wr_n_ff;
    nxt_rd_n      = rd_n_ff;
    nxt_cs_n      = cs_n_ff;
    nxt_rdy       = 1'h0;
    nxt_rsp       = 1'h0;
    // The strap is taken on the second edge after release, once the synchroniser holds the pins
    // rather than its own reset value; the address pins are still undriven then. R4
    if (strap_arm_ff == 2'h1) begin
      nxt_strap = addr_s;
    end
    unique case (state_ff)
      XBPI_IDLE: begin
        nxt_rdy = ~strap_arm_ff[1];
        if (req_valid && req_ready) begin
          nxt_rdy   = 1'h0;
          nxt_addr  = req_addr; // R3
          nxt_wdata = req_wdata;
          // In multiplexed mode the data lanes carry the low address while the latch enable is high.
          nxt_dout  = cfg_mux_mode ? req_addr[15:0] : req_wdata; // R2 R9
          nxt_write = req_write;
          nxt_idx   = cs_index(req_addr);
          nxt_sty   = cs_style(cs_index(req_addr), cfg_ds_style, cfg_hp_style); // R7 R8
          nxt_aoe   = 1'h1;
          nxt_doe   = cfg_mux_mode | req_write; // R9
          if (cfg_mux_mode) begin
            nxt_ale   = 1'h1; // R2
            nxt_state = XBPI_ALE;
          end else begin
            nxt_state = XBPI_SETUP;
          end
        end
      end
      XBPI_ALE: begin
        nxt_doe   = write_ff;
        nxt_dout  = wdata_ff; // R9
        nxt_state = XBPI_SETUP;
      end
      XBPI_SETUP: begin
        // Only one select goes low, the one the address decodes to. R15
        nxt_cs_n = ~(8'h01 << idx_ff);
        if (sty_ff == XBPI_STY_SEP) begin
          nxt_wr_n = ~write_ff; // R5
          nxt_rd_n = write_ff; // R6
        end else begin
          nxt_wr_n = 1'h0; // R5
          nxt_rd_n = ~write_ff; // R6
        end
        nxt_hold_cnt = 2'(XBPI_SYNC_STAGES);
        nxt_state = XBPI_STROBE;
      end
      XBPI_STROBE: begin
        // The first cycles let wait, ready and read data cross the synchronisers before they count.
        // The strobe phase is frozen while the target stalls. R10
        if (hold_cnt_ff != 2'h0) begin
          nxt_hold_cnt = hold_cnt_ff - 2'h1;
        end else if (!stall) begin
          nxt_rdata = data_s;
          nxt_wr_n  = 1'h1;
          nxt_rd_n  = 1'h1;
          nxt_state = XBPI_HOLD;
        end
      end
      XBPI_HOLD: begin
        nxt_cs_n  = XBPI_CS_IDLE;
        nxt_doe   = 1'h0;
        nxt_rsp   = 1'h1;
        nxt_state = XBPI_IDLE;
      end
      default: nxt_state = XBPI_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // Selects and strobes idle high, latch enable low, address released for strapping. R14 R4
      state_ff     <= XBPI_IDLE;
      strap_arm_ff <= 2'h3;
      hold_cnt_ff  <= 2'h0;
      dout_ff      <= XBPI_DATA_RST;
      strap_ff     <= XBPI_ADDR_RST;
      addr_ff      <= XBPI_ADDR_RST;
      wdata_ff     <= XBPI_DATA_RST;
      rdata_ff     <= XBPI_DATA_RST;
      write_ff     <= 1'h0;
      idx_ff       <= 3'h0;
      sty_ff       <= XBPI_STY_SEP;
      ale_ff       <= 1'h0;
      aoe_ff       <= 1'h0;
      doe_ff       <= 1'h0;
      wr_n_ff      <= 1'h1;
      rd_n_ff      <= 1'h1;
      cs_n_ff      <= XBPI_CS_IDLE;
      rdy_ff       <= 1'h0;
      rsp_ff       <= 1'h0;
    end else begin
      state_ff     <= nxt_state;
      strap_arm_ff <= nxt_strap_arm;
      hold_cnt_ff  <= nxt_hold_cnt;
      dout_ff      <= nxt_dout;
      strap_ff     <= nxt_strap;
      addr_ff      <= nxt_addr;
      wdata_ff     <= nxt_wdata;
      rdata_ff     <= nxt_rdata;
      write_ff     <= nxt_write;
      idx_ff       <= nxt_idx;
      sty_ff       <= nxt_sty;
      ale_ff       <= nxt_ale;
      aoe_ff       <= nxt_aoe;
      doe_ff       <= nxt_doe;
      wr_n_ff      <= nxt_wr_n;
      rd_n_ff      <= nxt_rd_n;
      cs_n_ff      <= nxt_cs_n;
      rdy_ff       <= nxt_rdy;
      rsp_ff       <= nxt_rsp;
    end
  end

  assign xbus_data_out       = dout_ff; // R2 R9
  assign xbus_addr_out       = addr_ff;
  assign xbus_addr_oe        = aoe_ff;
  assign xbus_data_oe        = doe_ff;
  assign xbus_addr_latch_en  = ale_ff;
  assign xbus_write_strobe_n = wr_n_ff;
  assign xbus_read_strobe_n  = rd_n_ff;
  assign xbus_select_n       = cs_n_ff;
  assign req_ready           = rdy_ff;
  assign rsp_valid           = rsp_ff;
  assign rsp_rdata           = rdata_ff;
  assign strap_cfg           = strap_ff;

  a_one_select: assert property (@(posedge clk) disable iff (srst)
    $countones(~xbus_select_n) <= 1) else $error("more than one chip select low"); // R15
  a_reset_idle: assert property (@(posedge clk)
    $past(srst) |-> xbus_select_n == 8'hFF && xbus_write_strobe_n && xbus_read_strobe_n && !xbus_addr_latch_en)
    else $error("pins not idle after reset"); // R14
  a_ale_mux: assert property (@(posedge clk) disable iff (srst)
    xbus_addr_latch_en |-> cfg_mux_mode ##1 !xbus_addr_latch_en) else $error("latch enable misuse"); // R2
  a_wait_freeze: assert property (@(posedge clk) disable iff (srst)
    state_ff == XBPI_STROBE && sty_ff != XBPI_STY_HP && !wait_n_s |=> state_ff == XBPI_STROBE)
    else $error("access moved during wait"); // R10
  a_hp_wait_ign: assert property (@(posedge clk) disable iff (srst)
    state_ff == XBPI_STROBE && sty_ff == XBPI_STY_HP && hold_cnt_ff == 2'h0 && rdy_act |=> state_ff == XBPI_HOLD)
    else $error("host-port access stalled despite ready"); // R11 R13
  a_hp_upper: assert property (@(posedge clk) disable iff (srst)
    sty_ff == XBPI_STY_HP && state_ff != XBPI_IDLE |-> idx_ff[2]) else $error("host-port on low select"); // R8
  a_sep_strobes: assert property (@(posedge clk) disable iff (srst)
    state_ff == XBPI_STROBE && $past(state_ff) == XBPI_SETUP && sty_ff == XBPI_STY_SEP
    |-> xbus_write_strobe_n == !write_ff && xbus_read_strobe_n == write_ff) else $error("separate strobe wrong"); // R5 R6
  a_ds_strobes: assert property (@(posedge clk) disable iff (srst)
    state_ff == XBPI_STROBE && sty_ff != XBPI_STY_SEP |-> !xbus_write_strobe_n && xbus_read_strobe_n == !write_ff)
    else $error("data strobe wrong"); // R5 R6
  a_data_drive: assert property (@(posedge clk) disable iff (srst)
    state_ff == XBPI_STROBE |-> xbus_data_oe == write_ff) else $error("data direction wrong"); // R9
endmodule

// ---- verilog/xbpi_pkg.sv ----
// Constants and types shared by the expansion bus pin interface.
package xbpi_pkg;
  localparam int unsigned XBPI_ADDR_W   = 24;
  localparam int unsigned XBPI_DATA_W   = 16;
  localparam int unsigned XBPI_NUM_CS   = 8;
  localparam int unsigned XBPI_NUM_RDY  = 4;
  localparam int unsigned XBPI_HP_FIRST = 4;
  localparam int unsigned XBPI_CS_POS   = 21;
  localparam logic [7:0]  XBPI_CS_IDLE  = 8'hFF;
  localparam logic [23:0] XBPI_ADDR_RST = 24'h000000;
  localparam logic [15:0] XBPI_DATA_RST = 16'h0000;
  localparam int unsigned XBPI_SYNC_STAGES = 2;
  // Separate-strobe, data-strobe and host-port styles.
  localparam logic [1:0]  XBPI_STY_SEP = 2'h0;
  localparam logic [1:0]  XBPI_STY_DS  = 2'h1;
  localparam logic [1:0]  XBPI_STY_HP  = 2'h2;
  typedef enum logic [2:0] {
    XBPI_IDLE,
    XBPI_ALE,
    XBPI_SETUP,
    XBPI_STROBE,
    XBPI_HOLD
  } xbpi_state_t;
endpackage

// ---- verilog/xbpi_sync.sv ----
// Two-stage synchroniser for inputs that arrive from the pins.
`timescale 1ns/1ps
module xbpi_sync
  import xbpi_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Pin side
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val,
  // Clock domain side
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // The reset value is a constant at every instance, so the output stage loads nothing variable under reset; the first stage keeps sampling the pins.
  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= srst ? rst_val : nxt_sync;
  end

  assign sync_out = sync_ff;
endmodule

// ---- dv/xbpi_far_model.sv ----
// Far-side model: one memory word per chip select, with a wait or ready that can come late.
`timescale 1ns/1ps
module xbpi_far_model
  import xbpi_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Pins driven by the design
  input  wire logic [7:0]  sel_n,
  input  wire logic        ws_n,
  input  wire logic        rs_n,
  input  wire logic [15:0] dout,
  input  wire logic        doe,
  input  wire logic        ale,
  // Configuration mirror and answer pace
  input  wire logic [7:0]  ds_style,
  input  wire logic [3:0]  hp_style,
  input  wire logic [3:0]  rdy_pol,
  input  wire logic [3:0]  slow,
  // Pins driven back and observations
  output logic      [15:0] mdrv,
  output logic             wait_n,
  output logic      [3:0]  rdy,
  output logic      [7:0]  seen,
  output logic      [1:0]  kind,
  output logic      [15:0] ale_word
);
  logic [15:0] mem [8];
  logic [15:0] last = 16'h0000;
  logic [3:0]  cnt = 4'h0;
  logic [2:0]  idx;
  logic        any, hp, sep, rd_on, wr_on;
  always_comb begin
    idx = 3'h0;
    for (int i = 0; i < 8; i++)
      if (!sel_n[i])
        idx = 3'(i);
    any = ~&sel_n;
    hp = idx[2] && hp_style[idx[1:0]];
    sep = !ds_style[idx] && !hp;
    rd_on = any && (sep ? !rs_n : !ws_n && rs_n);
    wr_on = any && (sep ? !ws_n : !ws_n && !rs_n);
    // A host-port target leaves wait low so that honouring it would hang the access.
    wait_n = !(any && hp) && cnt >= slow;
    for (int j = 0; j < 4; j++)
      rdy[j] = rdy_pol[j] ~^ ((any ? idx == 3'(j + 4) : 1'b1) && cnt >= slow);
    // A released bus toggles every cycle so that a mistimed sample cannot match.
    mdrv = (any && !doe) ? mem[idx] : ~last;
  end
  always_ff @(posedge clk) begin
    last <= mdrv;
    cnt <= any ? cnt + {3'h0, cnt != 4'hF} : 4'h0;
    seen <= (any && cnt == 4'h0) ? ~sel_n : seen | ~sel_n;
    kind <= (any && cnt == 4'h0) ? {wr_on, rd_on} : kind | {wr_on, rd_on};
    if (wr_on && doe)
      mem[idx] <= dout;
    if (ale)
      ale_word <= dout;
  end
endmodule

// ---- dv/xbpi_top_test.sv ----
// Self-checking bench: every chip select in separate and data-strobe style, the upper four in host-port style, with prompt and slow targets.
`timescale 1ns/1ps
module xbpi_top_test;
  import xbpi_pkg::*;
  localparam logic [23:0] STRAP = 24'hF3FF7E;
  logic        clk, srst, req_valid, req_write, req_ready, rsp_valid, cfg_mux_mode;
  logic        ale, aoe, ws_n, rs_n, doe, wait_n;
  logic [23:0] req_addr, strap_cfg, aout, ain;
  logic [15:0] req_wdata, rsp_rdata, dout, din, mdrv, ale_word;
  logic [7:0]  cfg_ds_style, sel_n, seen;
  logic [3:0]  cfg_hp_style, cfg_rdy_pol, rdy, slow;
  logic [1:0]  kind;
  int          errors, n_checks;
  // Undriven address pins float up; the board pulls a few of them low.
  assign ain = (aoe === 1'b1) ? aout : STRAP;
  assign din = (doe === 1'b1) ? dout : mdrv;
  xbpi_top i_dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .cfg_ds_style(cfg_ds_style), .cfg_hp_style(cfg_hp_style), .cfg_mux_mode(cfg_mux_mode),
    .cfg_rdy_pol(cfg_rdy_pol), .strap_cfg(strap_cfg), .xbus_addr_latch_en(ale), .xbus_addr_in(ain),
    .xbus_addr_out(aout), .xbus_addr_oe(aoe), .xbus_write_strobe_n(ws_n), .xbus_read_strobe_n(rs_n),
    .xbus_select_n(sel_n), .xbus_data_in(din), .xbus_data_out(dout), .xbus_data_oe(doe),
    .xbus_wait_n(wait_n), .hostport_ready(rdy));
  xbpi_far_model i_far (.clk(clk), .sel_n(sel_n), .ws_n(ws_n), .rs_n(rs_n), .dout(dout), .doe(doe), .ale(ale),
    .ds_style(cfg_ds_style), .hp_style(cfg_hp_style), .rdy_pol(cfg_rdy_pol), .slow(slow), .mdrv(mdrv),
    .wait_n(wait_n), .rdy(rdy), .seen(seen), .kind(kind), .ale_word(ale_word));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One access; sl is how many cycles the target keeps wait or ready off once selected.
  task automatic access(input int cs, input logic [1:0] sty, input logic wr, input logic [3:0] sl,
                        input logic [15:0] d);
    int lat;
    int nom;
    @(negedge clk);
    cfg_ds_style = (sty == XBPI_STY_SEP) ? 8'h00 : 8'h01 << cs;
    cfg_hp_style = (sty == XBPI_STY_HP) ? 4'h1 << (cs - 4) : 4'h0;
    slow = sl;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = {3'(cs), 5'h0A, d ^ 16'h5A5A};
    req_wdata = d;
    check({23'h0, req_ready}, 24'h1);
    @(negedge clk);
    req_valid = 1'b0;
    check({23'h0, req_ready}, 24'h0);
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 40) begin
      @(negedge clk);
      lat++;
    end
    // The strobe always spans the synchroniser stages before wait, ready or read data count.
    nom = (cfg_mux_mode ? 5 : 4) + XBPI_SYNC_STAGES;
    if (sl == 4'h0)
      check(24'(lat), 24'(nom));
    else
      check({23'h0, lat >= nom + sl && lat <= nom + sl + 3}, 24'h1);
    check({16'h0, seen}, 24'h1 << cs);
    check({22'h0, kind}, wr ? 24'h2 : 24'h1);
    check(aout, req_addr);
    if (cfg_mux_mode)
      check({8'h0, ale_word}, {8'h0, req_addr[15:0]});
    if (!wr)
      check({8'h0, rsp_rdata}, {8'h0, d});
  endtask
  task automatic t_reset();
    check({13'h0, sel_n, ws_n, rs_n, ale}, {13'h0, 8'hFF, 3'h6});
    repeat (2) @(negedge clk);
    check(strap_cfg, STRAP);
  endtask
  task automatic t_separate();
    for (int cs = 0; cs < 8; cs++) begin
      access(cs, XBPI_STY_SEP, 1'b1, 4'h0, 16'(16'hA5C3 ^ (cs << 8)));
      access(cs, XBPI_STY_SEP, 1'b0, 4'h3, 16'(16'hA5C3 ^ (cs << 8)));
    end
  endtask
  task automatic t_ds_mux();
    cfg_mux_mode = 1'b1;
    for (int cs = 0; cs < 8; cs++) begin
      access(cs, XBPI_STY_DS, 1'b1, 4'h0, 16'(16'h3C96 + cs));
      access(cs, XBPI_STY_DS, 1'b0, 4'h2, 16'(16'h3C96 + cs));
    end
    cfg_mux_mode = 1'b0;
  endtask
  // Ready polarity alternates so both senses are seen; each read must wait for its own ready.
  task automatic t_host_port();
    for (int cs = 4; cs < 8; cs++) begin
      cfg_rdy_pol = {4{cs[0]}};
      access(cs, XBPI_STY_HP, 1'b1, 4'h0, 16'(16'h0F1E << (cs - 4)));
      access(cs, XBPI_STY_HP, 1'b0, 4'h3, 16'(16'h0F1E << (cs - 4)));
    end
  endtask
  initial begin
    errors = 0;
    n_checks = 0;
    srst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    cfg_ds_style = 8'h00;
    cfg_hp_style = 4'h0;
    cfg_mux_mode = 1'b0;
    cfg_rdy_pol = 4'hF;
    slow = 4'h0;
    // The strap pins stand from time zero, so the first synchroniser stage holds them well before release.
    repeat (2) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_separate();
    t_ds_mux();
    t_host_port();
    print_verdict();
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule
